// ===== rtl/acsm_pkg.sv
// package: register map, field layout and source codes for the audio clock source muxes
// Functional notes
// [RULE_01] The dac divider source field, bits 6-4 of the dac/oversample select register, picks master, pll, oscillator, master pin, bit clock or gpio for codes 0 to 5 and mutes on any other code.
// [RULE_02] The oversample divider source field, bits 2-0, picks dac clock, master, pll, oscillator, master pin, bit clock or gpio for codes 0 to 6 and mutes on code 7.
// [RULE_03] The charge pump divider source field, bits 2-0 of its own register, uses the oversample code set and mutes on code 7.
// [RULE_04] With gpio as dsp divider source, pin field bits 6-4 picks general pin zero for 011 and general pin two for 101, and any other code mutes.
// [RULE_05] With gpio as dac divider source, pin field bits 2-0 picks general pin zero for 011 and general pin two for 101, and any other code mutes.
// [RULE_06] With gpio as charge pump divider source, pin field bits 6-4 picks general pin zero for 011 and general pin two for 101, and any other code mutes.
// [RULE_07] With gpio as oversample divider source, pin field bits 2-0 picks general pin zero for 011 and general pin two for 101, and any other code mutes.
// [RULE_08] The separate 3-bit dsp divider source field selects the gpio route with code 101, and then the dsp pin field picks the pin.
// [RULE_09] Reserved bits of the select registers hold and read back what software wrote, and have no function.
package acsm_pkg;

  localparam int unsigned ACSM_AW = 8;
  localparam int unsigned ACSM_DW = 8;

  localparam logic [7:0] ACSM_OFS_DAC_OVS_SEL  = 8'h0e;
  localparam logic [7:0] ACSM_OFS_PUMP_SEL     = 8'h0f;
  localparam logic [7:0] ACSM_OFS_DSP_DAC_PIN  = 8'h10;
  localparam logic [7:0] ACSM_OFS_PUMP_OVS_PIN = 8'h11;

  localparam logic [7:0] ACSM_RST_DAC_OVS_SEL  = 8'h00;
  localparam logic [7:0] ACSM_RST_PUMP_SEL     = 8'h00;
  localparam logic [7:0] ACSM_RST_DSP_DAC_PIN  = 8'h00;
  localparam logic [7:0] ACSM_RST_PUMP_OVS_PIN = 8'h00;

  localparam int unsigned ACSM_HI_LSB = 4;
  localparam int unsigned ACSM_LO_LSB = 0;

  // codes of the dac and dsp source fields
  localparam logic [2:0] ACSM_A_MASTER = 3'h0;
  localparam logic [2:0] ACSM_A_PLL    = 3'h1;
  localparam logic [2:0] ACSM_A_OSC    = 3'h2;
  localparam logic [2:0] ACSM_A_MPIN   = 3'h3;
  localparam logic [2:0] ACSM_A_BCLK   = 3'h4;
  localparam logic [2:0] ACSM_A_GPIO   = 3'h5;

  // codes of the oversample and charge pump source fields
  localparam logic [2:0] ACSM_B_DAC    = 3'h0;
  localparam logic [2:0] ACSM_B_MASTER = 3'h1;
  localparam logic [2:0] ACSM_B_PLL    = 3'h2;
  localparam logic [2:0] ACSM_B_OSC    = 3'h3;
  localparam logic [2:0] ACSM_B_MPIN   = 3'h4;
  localparam logic [2:0] ACSM_B_BCLK   = 3'h5;
  localparam logic [2:0] ACSM_B_GPIO   = 3'h6;

  // pin codes of the gpio pin fields
  localparam logic [2:0] ACSM_PIN_ZERO = 3'h3;
  localparam logic [2:0] ACSM_PIN_TWO  = 3'h5;

  typedef struct packed {
    logic master;
    logic pll;
    logic osc;
    logic mpin;
    logic bclk;
    logic general_pin_zero;
    logic general_pin_two;
  } acsm_src_t;

  typedef struct packed {
    logic                 wr;
    logic [ACSM_AW-1:0]   addr;
    logic [ACSM_DW-1:0]   wdata;
  } acsm_reg_req_t;

endpackage

// ===== rtl/acsm_gpio_route.sv
// one clock source mux stage: source code plus gpio pin code to a single clock
`timescale 1ns/1ps
module acsm_gpio_route
  import acsm_pkg::*;
(
  input  wire logic [2:0] src_code_i,
  input  wire logic [2:0] pin_code_i,
  input  wire logic [2:0] gpio_code_i,
  input  wire logic       code_b_i,
  input  wire logic       dac_clk_i,
  input  wire acsm_src_t  src_i,
  output logic            clk_o
);

  logic pin_clk;
  logic a_clk;
  logic b_clk;

  // only two pins exist; all other pin codes leave the route muted
  assign pin_clk = (pin_code_i == ACSM_PIN_ZERO) ? src_i.general_pin_zero :
                   (pin_code_i == ACSM_PIN_TWO)  ? src_i.general_pin_two  : 1'b0;

  always_comb begin
    case (src_code_i)
      ACSM_A_MASTER: a_clk = src_i.master;
      ACSM_A_PLL:    a_clk = src_i.pll;
      ACSM_A_OSC:    a_clk = src_i.osc;
      ACSM_A_MPIN:   a_clk = src_i.mpin;
      ACSM_A_BCLK:   a_clk = src_i.bclk;
      default:       a_clk = 1'b0;
    endcase
  end

  always_comb begin
    case (src_code_i)
      ACSM_B_DAC:    b_clk = dac_clk_i;
      ACSM_B_MASTER: b_clk = src_i.master;
      ACSM_B_PLL:    b_clk = src_i.pll;
      ACSM_B_OSC:    b_clk = src_i.osc;
      ACSM_B_MPIN:   b_clk = src_i.mpin;
      ACSM_B_BCLK:   b_clk = src_i.bclk;
      default:       b_clk = 1'b0;
    endcase
  end

  assign clk_o = (src_code_i == gpio_code_i) ? pin_clk : (code_b_i ? b_clk : a_clk);

endmodule

// ===== rtl/acsm_top.sv
// audio clock source muxes: select registers and the four divider clock routes
`timescale 1ns/1ps
module acsm_top
  import acsm_pkg::*;
(
  input  wire logic               core_clk_i,
  input  wire logic               reset_i,
  input  wire acsm_reg_req_t      reg_req_i,
  output logic [ACSM_DW-1:0]      reg_rdata_o,
  input  wire logic [2:0]         dsp_divider_source_i,
  input  wire acsm_src_t          src_i,
  output logic                    dac_clk_o,
  output logic                    oversample_clock_o,
  output logic                    charge_pump_clock_o,
  output logic                    dsp_clk_o
);

  logic [7:0] dac_ovs_sel_q;
  logic [7:0] pump_sel_q;
  logic [7:0] dsp_dac_pin_q;
  logic [7:0] pump_ovs_pin_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  wire wr_dac_ovs  = reg_req_i.wr && (reg_req_i.addr == ACSM_OFS_DAC_OVS_SEL);
  wire wr_pump     = reg_req_i.wr && (reg_req_i.addr == ACSM_OFS_PUMP_SEL);
  wire wr_dsp_dac  = reg_req_i.wr && (reg_req_i.addr == ACSM_OFS_DSP_DAC_PIN);
  wire wr_pump_ovs = reg_req_i.wr && (reg_req_i.addr == ACSM_OFS_PUMP_OVS_PIN);

  // whole bytes are stored so reserved bits read back as written
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      dac_ovs_sel_q  <= ACSM_RST_DAC_OVS_SEL;
      pump_sel_q     <= ACSM_RST_PUMP_SEL;
      dsp_dac_pin_q  <= ACSM_RST_DSP_DAC_PIN;
      pump_ovs_pin_q <= ACSM_RST_PUMP_OVS_PIN;
    end else begin
      if (wr_dac_ovs)  dac_ovs_sel_q  <= reg_req_i.wdata; // [RULE_09]
      if (wr_pump)     pump_sel_q     <= reg_req_i.wdata; // [RULE_09]
      if (wr_dsp_dac)  dsp_dac_pin_q  <= reg_req_i.wdata; // [RULE_09]
      if (wr_pump_ovs) pump_ovs_pin_q <= reg_req_i.wdata; // [RULE_09]
    end
  end

  assign rdata_d = (reg_req_i.addr == ACSM_OFS_DAC_OVS_SEL)  ? dac_ovs_sel_q  :
                   (reg_req_i.addr == ACSM_OFS_PUMP_SEL)     ? pump_sel_q     :
                   (reg_req_i.addr == ACSM_OFS_DSP_DAC_PIN)  ? dsp_dac_pin_q  :
                   (reg_req_i.addr == ACSM_OFS_PUMP_OVS_PIN) ? pump_ovs_pin_q : 8'h00;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) rdata_q <= 8'h00;
    else         rdata_q <= rdata_d;
  end
  assign reg_rdata_o = rdata_q;

  wire [2:0] dac_divider_source          = dac_ovs_sel_q[ACSM_HI_LSB +: 3];
  wire [2:0] oversample_divider_source   = dac_ovs_sel_q[ACSM_LO_LSB +: 3];
  wire [2:0] charge_pump_divider_source  = pump_sel_q[ACSM_LO_LSB +: 3];
  wire [2:0] dsp_gpio_pin_select         = dsp_dac_pin_q[ACSM_HI_LSB +: 3];
  wire [2:0] dac_gpio_pin_select         = dsp_dac_pin_q[ACSM_LO_LSB +: 3];
  wire [2:0] charge_pump_gpio_pin_select = pump_ovs_pin_q[ACSM_HI_LSB +: 3];
  wire [2:0] oversample_gpio_pin_select  = pump_ovs_pin_q[ACSM_LO_LSB +: 3];

  logic dac_clk;

  // clock routes are pure muxes; a glitch on reselect is the user's to avoid by halting the divider
  acsm_gpio_route u_dac ( // [RULE_01] [RULE_05]
    .src_code_i  (dac_divider_source),
    .pin_code_i  (dac_gpio_pin_select),
    .gpio_code_i (ACSM_A_GPIO),
    .code_b_i    (1'b0),
    .dac_clk_i   (1'b0),
    .src_i       (src_i),
    .clk_o       (dac_clk)
  );

  acsm_gpio_route u_ovs ( // [RULE_02] [RULE_07]
    .src_code_i  (oversample_divider_source),
    .pin_code_i  (oversample_gpio_pin_select),
    .gpio_code_i (ACSM_B_GPIO),
    .code_b_i    (1'b1),
    .dac_clk_i   (dac_clk),
    .src_i       (src_i),
    .clk_o       (oversample_clock_o)
  );

  acsm_gpio_route u_pump ( // [RULE_03] [RULE_06]
    .src_code_i  (charge_pump_divider_source),
    .pin_code_i  (charge_pump_gpio_pin_select),
    .gpio_code_i (ACSM_B_GPIO),
    .code_b_i    (1'b1),
    .dac_clk_i   (dac_clk),
    .src_i       (src_i),
    .clk_o       (charge_pump_clock_o)
  );

  acsm_gpio_route u_dsp ( // [RULE_08] [RULE_04]
    .src_code_i  (dsp_divider_source_i),
    .pin_code_i  (dsp_gpio_pin_select),
    .gpio_code_i (ACSM_A_GPIO),
    .code_b_i    (1'b0),
    .dac_clk_i   (1'b0),
    .src_i       (src_i),
    .clk_o       (dsp_clk_o)
  );

  assign dac_clk_o = dac_clk;

endmodule

// ===== tb/acsm_chk.sv
// checker: route and readback properties of the audio clock source muxes
`timescale 1ns/1ps
module acsm_chk
  import acsm_pkg::*;
(
  input wire logic               core_clk_i,
  input wire logic               reset_i,
  input wire acsm_reg_req_t      reg_req_i,
  input wire logic [ACSM_DW-1:0] reg_rdata_o,
  input wire logic [2:0]         dsp_divider_source_i,
  input wire acsm_src_t          src_i,
  input wire logic               dac_clk_o,
  input wire logic               oversample_clock_o,
  input wire logic               charge_pump_clock_o,
  input wire logic               dsp_clk_o
);
  logic [7:0] r_q [4];
  wire        hit = reg_req_i.addr >= 8'h0e && reg_req_i.addr <= 8'h11;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // shadow copy, so routes are judged without seeing the design's registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) r_q <= '{default: 8'h00};
    else if (reg_req_i.wr && hit) r_q[reg_req_i.addr[1:0] ^ 2'h2] <= reg_req_i.wdata;
  end
  a_dac_mute_code:
    assert property (r_q[0][6:4] > 3'h5 |-> !dac_clk_o) else $error("dac mute");
  a_ovs_dac_follow:
    assert property (r_q[0][2:0] == 3'h0 |-> oversample_clock_o == dac_clk_o)
      else $error("oversample route");
  a_pump_bclk_route:
    assert property (r_q[1][2:0] == 3'h5 |-> charge_pump_clock_o == src_i.bclk)
      else $error("pump route");
  a_dsp_pin_two:
    assert property (dsp_divider_source_i == 3'h5 && r_q[2][6:4] == 3'h5
      |-> dsp_clk_o == src_i.general_pin_two) else $error("dsp pin");
  a_dac_pin_zero:
    assert property (r_q[0][6:4] == 3'h5 && r_q[2][2:0] == 3'h3
      |-> dac_clk_o == src_i.general_pin_zero) else $error("dac pin");
  a_pump_pin_zero:
    assert property (r_q[1][2:0] == 3'h6 && r_q[3][6:4] == 3'h3
      |-> charge_pump_clock_o == src_i.general_pin_zero) else $error("pump pin");
  a_ovs_pin_two:
    assert property (r_q[0][2:0] == 3'h6 && r_q[3][2:0] == 3'h5
      |-> oversample_clock_o == src_i.general_pin_two) else $error("oversample pin");
  a_read_back:
    assert property (hit && !reg_req_i.wr |=> reg_rdata_o == $past(r_q[reg_req_i.addr[1:0] ^ 2'h2]))
      else $error("readback");
endmodule
bind acsm_top acsm_chk u_acsm_chk (.core_clk_i, .reset_i, .reg_req_i, .reg_rdata_o, .src_i,
  .dsp_divider_source_i, .dac_clk_o, .oversample_clock_o, .charge_pump_clock_o, .dsp_clk_o);

// ===== tb/testbench.sv
// testbench: self-checking scenarios for the audio clock source muxes
`timescale 1ns/1ps
module testbench
  import acsm_pkg::*;
;
  logic          core_clk_i = 1'b0;
  logic          reset_i = 1'b1;
  acsm_reg_req_t reg_req_i = '0;
  logic [7:0]    reg_rdata_o;
  logic [2:0]    dsp_divider_source_i = 3'h0;
  acsm_src_t     src_i = '0;
  wire [3:0]     clks;
  int            bad_count = 0;
  int            check_count = 0;
  int            cyc = 0;
  acsm_top u_acsm_top (.core_clk_i, .reset_i, .reg_req_i, .reg_rdata_o, .dsp_divider_source_i,
    .src_i, .dac_clk_o(clks[0]), .oversample_clock_o(clks[1]), .charge_pump_clock_o(clks[2]),
    .dsp_clk_o(clks[3]));
  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i) reg_req_i = '{1'b1, a, d};
    @(negedge core_clk_i) reg_req_i.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk_i) reg_req_i.addr = a;
    @(negedge core_clk_i) chk(reg_rdata_o, exp);
  endtask
  // idx is the source bit that must come through; -1 means a muted route
  task automatic route(input int k, input int idx);
    for (int v = 0; v < 2; v++) begin
      @(negedge core_clk_i) src_i = idx < 0 ? {7{v[0]}} : (v[0] ? 7'h1 << idx : ~(7'h1 << idx));
      #1 chk({7'h0, clks[k]}, {7'h0, idx >= 0 && v[0]});
    end
  endtask
  task automatic t_reset_state();
    for (int a = 14; a < 18; a++) rd(8'(a), 8'h00);
    for (int k = 0; k < 4; k++) route(k, 6);
  endtask
  task automatic t_dac_codes();
    int tab[8] = '{6, 5, 4, 3, 2, 1, -1, -1};
    wr(8'h10, 8'h03);
    for (int c = 0; c < 8; c++) begin
      wr(8'h0e, 8'(c << 4));
      route(0, tab[c]);
      route(1, tab[c]);
    end
    wr(8'h0e, 8'h50);
    route(0, 1);
    wr(8'h10, 8'h05);
    route(0, 0);
    wr(8'h10, 8'h02);
    route(0, -1);
  endtask
  task automatic t_ovs_pump_codes();
    int otab[8] = '{5, 6, 5, 4, 3, 2, 0, -1};
    int ctab[8] = '{5, 6, 5, 4, 3, 2, 1, -1};
    wr(8'h11, 8'h35);
    for (int c = 0; c < 8; c++) begin
      wr(8'h0e, 8'(8'h10 | c));
      wr(8'h0f, 8'(c));
      route(1, otab[c]);
      route(2, ctab[c]);
    end
  endtask
  task automatic t_dsp_pins();
    @(negedge core_clk_i) dsp_divider_source_i = 3'h5;
    for (int p = 0; p < 8; p++) begin
      wr(8'h10, 8'(p << 4));
      route(3, p == 3 ? 1 : p == 5 ? 0 : -1);
    end
    // pin field is left at 7 here, so the gpio code must mute as well
    for (int c = 0; c < 8; c++) begin
      @(negedge core_clk_i) dsp_divider_source_i = 3'(c);
      route(3, c < 5 ? 6 - c : -1);
    end
  endtask
  task automatic t_readback();
    wr(8'h0e, 8'hff);
    wr(8'h12, 8'h5a);
    rd(8'h0e, 8'hff);
    rd(8'h11, 8'h35);
    rd(8'h0f, 8'h07);
    rd(8'h12, 8'h00);
  endtask
  // a second reset must undo the muted dac code left by the readback scenario
  task automatic t_mid_reset();
    @(negedge core_clk_i) reset_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    reset_i = 1'b0;
    rd(8'h0e, 8'h00);
    rd(8'h11, 8'h00);
    route(0, 6);
    route(2, 6);
  endtask
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  // ceiling far above the few hundred cycles the scenarios need
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(negedge core_clk_i);
    reset_i = 1'b0;
    t_reset_state();
    t_dac_codes();
    t_ovs_pump_codes();
    t_dsp_pins();
    t_readback();
    t_mid_reset();
    wrap_up();
  end
endmodule
